// >>> include/brf_params.svh
// brf_params.svh: register offsets, status word fields, mode codes, reset values
// assumes: included by bare name from the design and testbench files
// Operation
// - two instruction states: 32-bit wide and 16-bit compact.
// - three-stage fetch, decode, execute pipeline over one shared memory path.
// - byte, half-word, word accesses; words and half-words naturally aligned.
// - seven modes; only user mode is unprivileged.
// - 37 physical registers: 31 general of 32 bits plus 6 status words.
// - exactly 16 general registers visible at any moment.
// - register 15 is the program counter, usable as relative base.
// - registers 0-7 shared in every mode; 8-14 chosen by mode.
// - each exception mode has private registers 13 and 14.
// - fast interrupt mode also has private registers 8 to 12.
// - system mode uses user registers, privileged, all exceptions allowed.
// - on exception entry the mode's register 14 gets the return address.
// - a subroutine call writes the return address into register 14.
// - status word holds NZCV flags, two disables, state bit, mode field.
// - each exception mode saves the interrupted status word on entry.
// - five exception types, each entering its own privileged mode.
// - return copies saved status word back and register 14 into PC.
// - wide instructions carry condition in bits 31:28; execute only if true.
// - mode changes by software, external interrupt or exception.
// - compact state registers 0-7 are the same physical registers.
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH
// axi-lite word offsets (byte addresses)
`define BRF_OFF_STATUS 8'h00
`define BRF_OFF_SAVED  8'h04
`define BRF_OFF_EXCREQ 8'h08
`define BRF_OFF_RETURN 8'h0C
`define BRF_OFF_CALL   8'h10
`define BRF_OFF_COND   8'h14
`define BRF_OFF_ACCESS 8'h18
`define BRF_OFF_STEP   8'h1C
`define BRF_OFF_INFO   8'h20
`define BRF_OFF_GPR    8'h40
`define BRF_RESP_OK    2'h0
`define BRF_RESP_ERR   2'h2
// status word fields
`define BRF_F_N 31
`define BRF_F_Z 30
`define BRF_F_C 29
`define BRF_F_V 28
`define BRF_F_I 7
`define BRF_F_F 6
`define BRF_F_T 5
`define BRF_USER_WMASK 32'hF000_0000
`define BRF_STATUS_RST 32'h0000_00D3
// mode codes
`define BRF_MODE_USR 5'h10
`define BRF_MODE_FIQ 5'h11
`define BRF_MODE_IRQ 5'h12
`define BRF_MODE_SVC 5'h13
`define BRF_MODE_ABT 5'h17
`define BRF_MODE_UND 5'h1B
`define BRF_MODE_SYS 5'h1F
// exception kinds in priority order, and their vectors
`define BRF_EXC_N     5
`define BRF_EXC_ABT   0
`define BRF_EXC_FIQ   1
`define BRF_EXC_IRQ   2
`define BRF_EXC_UND   3
`define BRF_EXC_TRAP  4
`define BRF_VEC_ABT   32'h0000_000C
`define BRF_VEC_FIQ   32'h0000_0014
`define BRF_VEC_IRQ   32'h0000_0010
`define BRF_VEC_UND   32'h0000_0004
`define BRF_VEC_TRAP  32'h0000_0008
// physical register layout
`define BRF_NPHYS   31
`define BRF_NSAVED  5
`define BRF_PC_IDX  5'h1E
`define BRF_LEN_WIDE    32'h0000_0004
`define BRF_LEN_COMPACT 32'h0000_0002
`endif

// >>> include/brf_pkg.sv
// brf_pkg: shared types of the banked register file
// assumes: brf_params.svh is on the include path
package brf_pkg;
  typedef logic [31:0] brf_word_t;
  typedef logic [4:0]  brf_mode_t;
  typedef logic [4:0]  brf_exc_vec_t;
endpackage : brf_pkg

// >>> rtl/brf_exc_arb.sv
// brf_exc_arb: fixed-priority pick among pending exceptions, bit 0 highest
// assumes: requests already gated by the interrupt disable bits
`timescale 1ns/1ps
module brf_exc_arb #(
  parameter int N = 5
) (
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] grant,
  output logic              any
);
  logic [N:0] seen;

  // a request wins only if no higher one is pending; losers stay pending
  assign seen[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pri
      assign grant[i]  = req[i] & ~seen[i];
      assign seen[i+1] = seen[i] | req[i];
    end
  endgenerate
  assign any = seen[N];
endmodule : brf_exc_arb

// >>> rtl/brf_core_state.sv
// brf_core_state: banked register file, status words, exception entry and return
// assumes: axi-lite master on aclk; interrupt and abort pins are asynchronous
`timescale 1ns/1ps
`include "brf_params.svh"
module brf_core_state (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire brf_pkg::brf_word_t wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output brf_pkg::brf_word_t     rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              fast_irq_in,
  input  wire logic              irq_in,
  input  wire logic              abort_in,
  output brf_pkg::brf_mode_t     cur_mode,
  output logic                   compact_state,
  output logic                   privileged,
  output logic                   exc_taken
);
  import brf_pkg::*;

  // map (mode, visible index) to one of 31 physical registers
  function automatic logic [4:0] phys_idx(input brf_mode_t m, input logic [3:0] r);
    logic [4:0] base;
    base = 5'h0D;
    case (m)
      `BRF_MODE_IRQ: base = 5'h16;
      `BRF_MODE_SVC: base = 5'h18;
      `BRF_MODE_ABT: base = 5'h1A;
      `BRF_MODE_UND: base = 5'h1C;
      default:       base = 5'h0D; // user and system share
    endcase
    if (r == 4'hF) phys_idx = `BRF_PC_IDX;
    else if (r < 4'h8) phys_idx = {1'b0, r};
    else if (m == `BRF_MODE_FIQ) phys_idx = {1'b0, r} + 5'h07;
    else if (r < 4'hD) phys_idx = {1'b0, r};
    else phys_idx = base + {1'b0, r} - 5'h0D;
  endfunction : phys_idx

  // saved status word slot of a mode, 7 when the mode has none
  function automatic logic [2:0] saved_idx(input brf_mode_t m);
    case (m)
      `BRF_MODE_FIQ: saved_idx = 3'h0;
      `BRF_MODE_IRQ: saved_idx = 3'h1;
      `BRF_MODE_SVC: saved_idx = 3'h2;
      `BRF_MODE_ABT: saved_idx = 3'h3;
      `BRF_MODE_UND: saved_idx = 3'h4;
      default:       saved_idx = 3'h7;
    endcase
  endfunction : saved_idx

  function automatic logic mode_legal(input brf_mode_t m);
    case (m)
      `BRF_MODE_USR, `BRF_MODE_FIQ, `BRF_MODE_IRQ, `BRF_MODE_SVC,
      `BRF_MODE_ABT, `BRF_MODE_UND, `BRF_MODE_SYS: mode_legal = 1'b1;
      default: mode_legal = 1'b0;
    endcase
  endfunction : mode_legal

  // condition field against the result flags
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      4'h0: cond_ok = z;
      4'h1: cond_ok = !z;
      4'h2: cond_ok = cy;
      4'h3: cond_ok = !cy;
      4'h4: cond_ok = n;
      4'h5: cond_ok = !n;
      4'h6: cond_ok = v;
      4'h7: cond_ok = !v;
      4'h8: cond_ok = cy & !z;
      4'h9: cond_ok = !cy | z;
      4'hA: cond_ok = n == v;
      4'hB: cond_ok = n != v;
      4'hC: cond_ok = !z & (n == v);
      4'hD: cond_ok = z | (n != v);
      4'hE: cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  endfunction : cond_ok

  // bus state
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  brf_word_t   wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  brf_word_t   rdata_r, rdata_nxt;
  // core state
  brf_word_t   phys_r [`BRF_NPHYS];
  brf_word_t   phys_nxt [`BRF_NPHYS];
  brf_word_t   saved_r [`BRF_NSAVED];
  brf_word_t   saved_nxt [`BRF_NSAVED];
  brf_word_t   status_r, status_nxt;
  brf_exc_vec_t pend_r, pend_nxt;
  logic [2:0]  sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic        cond_pass_r, cond_pass_nxt, misalign_r, misalign_nxt;
  logic        bad_ret_r, bad_ret_nxt, taken_r, taken_nxt, priv_r, priv_nxt;
  logic [2:0]  last_exc_r, last_exc_nxt;
  // combinational helpers
  logic        do_wr, wr_err;
  brf_mode_t   mode;
  brf_word_t   len, pc, wmask, rd_word;
  logic [3:0]  rd_idx;
  brf_exc_vec_t eff_req, grant;
  logic        grant_any;

  assign mode  = status_r[4:0];
  assign pc    = phys_r[`BRF_PC_IDX];
  // instruction length follows the state bit
  assign len   = status_r[`BRF_F_T] ? `BRF_LEN_COMPACT : `BRF_LEN_WIDE;
  assign do_wr = aw_held_r & w_held_r & !bvalid_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // disable bits gate the interrupt kinds; interrupt pins are level requests, the abort pin is latched into pend_r
  always_comb begin
    eff_req = pend_r;
    eff_req[`BRF_EXC_FIQ] = (pend_r[`BRF_EXC_FIQ] | sync2_r[0]) & !status_r[`BRF_F_F];
    eff_req[`BRF_EXC_IRQ] = (pend_r[`BRF_EXC_IRQ] | sync2_r[1]) & !status_r[`BRF_F_I];
  end

  brf_exc_arb #(
    .N (`BRF_EXC_N)
  ) u_arb (
    .req   (eff_req),
    .grant (grant),
    .any   (grant_any)
  );

  // read mux; r15 shows the fetch address two instructions ahead
  assign rd_idx = araddr[5:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr)
      `BRF_OFF_STATUS: rd_word = status_r;
      `BRF_OFF_SAVED:  if (saved_idx(mode) != 3'h7) rd_word = saved_r[saved_idx(mode)];
      `BRF_OFF_EXCREQ: rd_word = {27'h000_0000, pend_r};
      `BRF_OFF_COND:   rd_word = {31'h0000_0000, cond_pass_r};
      `BRF_OFF_ACCESS: rd_word = {31'h0000_0000, misalign_r};
      `BRF_OFF_INFO:   rd_word = {16'h0000, status_r[`BRF_F_T], last_exc_r, priv_r,
                                  bad_ret_r, misalign_r, cond_pass_r, 3'h0, eff_req};
      default: begin
        if (araddr[7:6] == 2'h1 && araddr[1:0] == 2'h0) begin
          if (rd_idx == 4'hF) rd_word = pc + (len << 1);
          else rd_word = phys_r[phys_idx(mode, rd_idx)];
        end
      end
    endcase
  end

  // axi-lite slave: address and data taken in either order, answer follows both
  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_held_nxt = aw_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    w_held_nxt  = w_held_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    arready_nxt = arready_r;
    if (awvalid && awready_r) begin
      awaddr_nxt  = awaddr;
      aw_held_nxt = 1'b1;
    end
    if (wvalid && wready_r) begin
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
      w_held_nxt = 1'b1;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_err ? `BRF_RESP_ERR : `BRF_RESP_OK;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // ready drops while a word is held, so nothing is overwritten
    awready_nxt = !aw_held_nxt;
    wready_nxt  = !w_held_nxt;
    if (arvalid && arready_r) begin
      rvalid_nxt  = 1'b1;
      arready_nxt = 1'b0;
      rdata_nxt   = rd_word;
      rresp_nxt   = (araddr[1:0] != 2'h0 || (araddr > `BRF_OFF_INFO &&
                     araddr < `BRF_OFF_GPR) || araddr[7]) ? `BRF_RESP_ERR : `BRF_RESP_OK;
    end else if (rvalid_r && rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // core state: software writes first, otherwise one exception per cycle
  always_comb begin
    brf_word_t  nw, ret;
    brf_mode_t  nm;
    logic [2:0] k;
    phys_nxt      = phys_r;
    saved_nxt     = saved_r;
    status_nxt    = status_r;
    pend_nxt      = pend_r;
    cond_pass_nxt = cond_pass_r;
    misalign_nxt  = misalign_r;
    bad_ret_nxt   = bad_ret_r;
    last_exc_nxt  = last_exc_r;
    taken_nxt     = 1'b0;
    wr_err        = 1'b0;
    nw            = 32'h0000_0000;
    ret           = 32'h0000_0000;
    nm            = mode;
    k             = 3'h0;
    sync1_nxt     = {abort_in, irq_in, fast_irq_in};
    sync2_nxt     = sync1_r;
    pend_nxt[`BRF_EXC_ABT] = pend_r[`BRF_EXC_ABT] | sync2_r[2];
    if (do_wr) begin
      case (awaddr_r)
        `BRF_OFF_STATUS: begin
          // user mode may change the flags only
          nw = (status_r & ~wmask) | (wdata_r & wmask);
          if (mode == `BRF_MODE_USR)
            nw = (status_r & ~`BRF_USER_WMASK) | (nw & `BRF_USER_WMASK);
          if (!mode_legal(nw[4:0])) nw[4:0] = mode;
          status_nxt = nw;
        end
        `BRF_OFF_SAVED: begin
          if (saved_idx(mode) != 3'h7)
            saved_nxt[saved_idx(mode)] = (saved_r[saved_idx(mode)] & ~wmask) | (wdata_r & wmask);
          else wr_err = 1'b1;
        end
        // a software request adds to the pending bits, keeping an abort latched this cycle
        `BRF_OFF_EXCREQ: pend_nxt = pend_nxt | wdata_r[4:0];
        `BRF_OFF_RETURN: begin
          k = saved_idx(mode);
          if (k != 3'h7) begin
            status_nxt = saved_r[k];
            phys_nxt[`BRF_PC_IDX] = phys_r[phys_idx(mode, 4'hE)] & ~32'h0000_0001;
            bad_ret_nxt = 1'b0;
          end else begin
            bad_ret_nxt = 1'b1;
            wr_err      = 1'b1;
          end
        end
        `BRF_OFF_CALL: begin
          phys_nxt[phys_idx(mode, 4'hE)] = pc + len;
          phys_nxt[`BRF_PC_IDX] = wdata_r & ~(len - 32'h0000_0001);
        end
        // compact instructions carry no condition field and always pass
        `BRF_OFF_COND: cond_pass_nxt = status_r[`BRF_F_T] ? 1'b1 :
                                       cond_ok(wdata_r[31:28], status_r[31:28]);
        `BRF_OFF_ACCESS: misalign_nxt = (wdata_r[5:4] == 2'h1 && wdata_r[0]) ||
                                        (wdata_r[5:4] == 2'h2 && wdata_r[1:0] != 2'h0) ||
                                        wdata_r[5:4] == 2'h3;
        `BRF_OFF_STEP: phys_nxt[`BRF_PC_IDX] = pc + len;
        default: begin
          if (awaddr_r[7:6] == 2'h1 && awaddr_r[1:0] == 2'h0) begin
            // same physical r0-r7 in either state
            nw = (phys_r[phys_idx(mode, awaddr_r[5:2])] & ~wmask) | (wdata_r & wmask);
            if (awaddr_r[5:2] == 4'hF) nw = nw & ~(len - 32'h0000_0001);
            phys_nxt[phys_idx(mode, awaddr_r[5:2])] = nw;
          end else begin
            wr_err = 1'b1;
          end
        end
      endcase
    end else if (grant_any) begin
      // entry: save status, link the return address, switch mode, vector
      for (int j = 0; j < `BRF_EXC_N; j++)
        if (grant[j]) k = 3'(j);
      case (k)
        3'h0:    begin nm = `BRF_MODE_ABT; ret = `BRF_VEC_ABT; end
        3'h1:    begin nm = `BRF_MODE_FIQ; ret = `BRF_VEC_FIQ; end
        3'h2:    begin nm = `BRF_MODE_IRQ; ret = `BRF_VEC_IRQ; end
        3'h3:    begin nm = `BRF_MODE_UND; ret = `BRF_VEC_UND; end
        default: begin nm = `BRF_MODE_SVC; ret = `BRF_VEC_TRAP; end
      endcase
      saved_nxt[saved_idx(nm)] = status_r;
      phys_nxt[phys_idx(nm, 4'hE)] = pc + len;
      phys_nxt[`BRF_PC_IDX] = ret;
      status_nxt[4:0] = nm;
      status_nxt[`BRF_F_T] = 1'b0;
      status_nxt[`BRF_F_I] = 1'b1;
      if (k == 3'h1) status_nxt[`BRF_F_F] = 1'b1;
      pend_nxt     = pend_nxt & ~grant;
      last_exc_nxt = k;
      taken_nxt    = 1'b1;
    end
    priv_nxt = status_nxt[4:0] != `BRF_MODE_USR;
  end

  // register both groups; reset lands in supervisor, wide state, interrupts off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r    <= 8'h00;
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      wdata_r     <= 32'h0000_0000;
      wstrb_r     <= 4'h0;
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      arready_r   <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `BRF_RESP_OK;
      rvalid_r    <= 1'b0;
      rresp_r     <= `BRF_RESP_OK;
      rdata_r     <= 32'h0000_0000;
      for (int j = 0; j < `BRF_NPHYS; j++) phys_r[j] <= 32'h0000_0000;
      for (int j = 0; j < `BRF_NSAVED; j++) saved_r[j] <= 32'h0000_0000;
      status_r    <= `BRF_STATUS_RST;
      pend_r      <= 5'h00;
      sync1_r     <= 3'h0;
      sync2_r     <= 3'h0;
      cond_pass_r <= 1'b0;
      misalign_r  <= 1'b0;
      bad_ret_r   <= 1'b0;
      last_exc_r  <= 3'h0;
      taken_r     <= 1'b0;
      priv_r      <= 1'b1;
    end else begin
      awaddr_r    <= awaddr_nxt;
      aw_held_r   <= aw_held_nxt;
      w_held_r    <= w_held_nxt;
      wdata_r     <= wdata_nxt;
      wstrb_r     <= wstrb_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      arready_r   <= arready_nxt | (!rvalid_nxt & !arready_r & !rvalid_r);
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      phys_r      <= phys_nxt;
      saved_r     <= saved_nxt;
      status_r    <= status_nxt;
      pend_r      <= pend_nxt;
      sync1_r     <= sync1_nxt;
      sync2_r     <= sync2_nxt;
      cond_pass_r <= cond_pass_nxt;
      misalign_r  <= misalign_nxt;
      bad_ret_r   <= bad_ret_nxt;
      last_exc_r  <= last_exc_nxt;
      taken_r     <= taken_nxt;
      priv_r      <= priv_nxt;
    end
  end

  // outputs straight from flops
  assign awready       = awready_r;
  assign wready        = wready_r;
  assign bvalid        = bvalid_r;
  assign bresp         = bresp_r;
  assign arready       = arready_r;
  assign rvalid        = rvalid_r;
  assign rresp         = rresp_r;
  assign rdata         = rdata_r;
  assign cur_mode      = status_r[4:0];
  assign compact_state = status_r[`BRF_F_T];
  assign privileged    = priv_r;
  assign exc_taken     = taken_r;
endmodule : brf_core_state

// >>> testbench/brf_core_state_chk.sv
// brf_core_state_chk: bus and mode checks on the core ports
// assumes: bound to brf_core_state; aresetn synchronous active low
`timescale 1ns/1ps
`include "brf_params.svh"
module brf_core_state_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata,
  input wire logic [4:0]  cur_mode,
  input wire logic        compact_state,
  input wire logic        privileged,
  input wire logic        exc_taken
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // accept steps
  sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_taken; arvalid && arready; endsequence
  // read answer next edge, no second read meanwhile
  property p_rd_lat; s_rd_taken |=> rvalid && !arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("rd late");
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rd dropped");
  property p_wr_lat; s_wr_taken |-> ##2 bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("wr late");
  property p_aw_busy; awvalid && awready |=> !awready; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("aw twice");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_rd_err; rvalid && rresp == `BRF_RESP_ERR |-> rdata == 32'h0000_0000; endproperty
  a_rd_err: assert property (p_rd_err) else $error("err rd data");
  // entry lands privileged, wide, not system
  property p_exc_mode;
    exc_taken |-> privileged && !compact_state && cur_mode != `BRF_MODE_SYS;
  endproperty
  a_exc_mode: assert property (p_exc_mode) else $error("bad entry mode");
  property p_priv; privileged == (cur_mode != `BRF_MODE_USR); endproperty
  a_priv: assert property (p_priv) else $error("priv wrong");
endmodule : brf_core_state_chk

// >>> testbench/brf_irq_src.sv
// brf_irq_src: interrupt and abort sources facing the core
// assumes: tasks are called just after a rising aclk edge
`timescale 1ns/1ps
module brf_irq_src (
  input  wire logic aclk,
  output logic      fast_irq_in,
  output logic      irq_in,
  output logic      abort_in
);
  // lines rest low until a source raises them
  initial begin
    {fast_irq_in, irq_in, abort_in} = 3'h0;
  end
  task automatic set_lines(input logic f, input logic i);
    @(posedge aclk);
    fast_irq_in <= f;
    irq_in <= i;
  endtask : set_lines
  // two cycles wide so the synchroniser sees it
  task automatic pulse_abort();
    @(posedge aclk);
    abort_in <= 1'b1;
    repeat (2) @(posedge aclk);
    abort_in <= 1'b0;
  endtask : pulse_abort
endmodule : brf_irq_src

// >>> testbench/brf_core_state_tb.sv
// brf_core_state_tb: self-checking bench for the banked register file
// assumes: brf_params.svh on the include path
`timescale 1ns/1ps
`include "brf_params.svh"
module brf_core_state_tb;
  import brf_pkg::*;
  logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic       bvalid, arready, rvalid, compact_state, privileged, exc_taken;
  logic       fast_irq_in, irq_in, abort_in;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  brf_word_t  wdata, rdata;
  brf_mode_t  cur_mode, last_mode;
  brf_mode_t  mlog[$];
  int         num_errors, n_compared, cyc;

  brf_core_state DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .fast_irq_in, .irq_in, .abort_in, .cur_mode,
    .compact_state, .privileged, .exc_taken);
  brf_irq_src PARTNER (.aclk, .fast_irq_in, .irq_in, .abort_in);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // mode history for entry order; hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    last_mode <= cur_mode;
    if (cur_mode !== last_mode) mlog.push_back(cur_mode);
    if (cyc == 20000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input brf_word_t got, input brf_word_t exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] g(input int n);
    return 8'(`BRF_OFF_GPR + 4 * n);
  endfunction : g

  // odd codes up to 13 invert even ones; 14 and 15 always pass
  function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v, b;
    {n, z, cy, v} = f;
    case (c[3:1])
      3'd0: b = z;
      3'd1: b = cy;
      3'd2: b = n;
      3'd3: b = v;
      3'd4: b = cy & ~z;
      3'd5: b = (n == v);
      3'd6: b = ~z & (n == v);
      default: return 1'b1;
    endcase
    return b ^ c[0];
  endfunction : cpass

  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input brf_word_t d, input logic [1:0] er = 2'h0);
    logic ad = 1'b0, wd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input brf_word_t exp, input string what,
                    input brf_word_t m = 32'hFFFF_FFFF, input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata & m, exp, what);
    chk({30'h0, rresp}, {30'h0, er}, what);
  endtask : rd

  task automatic wait_log(input int n);
    for (int i = 0; i < 60 && mlog.size() < n; i++) @(posedge aclk);
    chk(32'(mlog.size()), 32'(n), "entries");
  endtask : wait_log

  task automatic t_reset();
    chk({24'h0, cur_mode, privileged, compact_state, exc_taken}, 32'h0000_009C, "rst");
    rd(`BRF_OFF_STATUS, `BRF_STATUS_RST, "rst st");
    rd(8'h24, 32'h0, "unmap", 32'hFFFF_FFFF, `BRF_RESP_ERR);
    wr(8'h24, 32'h1, `BRF_RESP_ERR);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bank();
    wr(g(0), 32'h0000_00A0);
    wr(g(13), 32'h0000_005C);
    wr(`BRF_OFF_STATUS, 32'h0000_00D0);
    chk({31'h0, privileged}, 32'h0, "user priv");
    rd(g(0), 32'h0000_00A0, "r0");
    rd(g(13), 32'h0, "user sp");
    wr(g(15), 32'h0000_0100);
    wr(`BRF_OFF_STATUS, 32'hF000_00DF);
    rd(`BRF_OFF_STATUS, 32'hF000_00D0, "user st");
    wr(`BRF_OFF_SAVED, 32'h1, `BRF_RESP_ERR);
    wr(`BRF_OFF_RETURN, 32'h0, `BRF_RESP_ERR);
    wr(`BRF_OFF_EXCREQ, 32'h0000_0010);
    rd(`BRF_OFF_STATUS, 32'hF000_00D3, "trap st");
    rd(`BRF_OFF_SAVED, 32'hF000_00D0, "saved");
    rd(g(14), 32'h0000_0104, "lr");
    rd(g(13), 32'h0000_005C, "svc sp");
    rd(g(15), 32'h0000_0010, "pc");
    wr(`BRF_OFF_RETURN, 32'h0);
    rd(`BRF_OFF_STATUS, 32'hF000_00D0, "ret st");
    rd(g(15), 32'h0000_010C, "pc back");
    wr(`BRF_OFF_EXCREQ, 32'h0000_0010);
    wr(`BRF_OFF_STATUS, 32'h0000_00DF);
    rd(g(13), 32'h0, "sys sp");
    wr(`BRF_OFF_STATUS, 32'h0000_00D3);
    $display("test bank done");
  endtask : t_bank

  task automatic t_fiq();
    wr(g(8), 32'h0000_0088);
    wr(`BRF_OFF_STATUS, 32'h0000_0013);
    mlog.delete();
    PARTNER.set_lines(1'b1, 1'b1);
    wait_log(1);
    PARTNER.set_lines(1'b0, 1'b0);
    chk({27'h0, mlog[0]}, {27'h0, `BRF_MODE_FIQ}, "fiq");
    rd(`BRF_OFF_STATUS, 32'h0000_00D1, "fiq st");
    rd(`BRF_OFF_SAVED, 32'h0000_0013, "fiq sv");
    rd(g(8), 32'h0, "fiq r8");
    wr(g(8), 32'h0000_0099);
    chk(32'(mlog.size()), 32'h1, "masked");
    wr(`BRF_OFF_RETURN, 32'h0);
    rd(g(8), 32'h0000_0088, "svc r8");
    $display("test fiq done");
  endtask : t_fiq

  task automatic t_prio();
    mlog.delete();
    wr(`BRF_OFF_EXCREQ, 32'h0000_0019);
    wait_log(3);
    chk(32'({mlog[0], mlog[1], mlog[2]}), 32'h0000_5F73, "order");
    wr(`BRF_OFF_STATUS, 32'h0000_0013);
    mlog.delete();
    PARTNER.set_lines(1'b0, 1'b1);
    wait_log(1);
    PARTNER.set_lines(1'b0, 1'b0);
    PARTNER.pulse_abort();
    wait_log(2);
    chk(32'({mlog[0], mlog[1]}), 32'h0000_0257, "irq abort");
    $display("test prio done");
  endtask : t_prio

  task automatic t_cond();
    for (int f = 0; f < 16; f += 5) begin
      wr(`BRF_OFF_STATUS, {f[3:0], 28'h000_00D3});
      for (int c = 0; c < 15; c++) begin
        wr(`BRF_OFF_COND, {c[3:0], 28'h000_0000});
        rd(`BRF_OFF_COND, {31'h0, cpass(c[3:0], f[3:0])}, "cond", 32'h1);
      end
    end
    for (int s = 0; s < 3; s++) begin
      for (int a = 0; a < 4; a++) begin
        wr(`BRF_OFF_ACCESS, {26'h0, s[1:0], 2'h0, a[1:0]});
        rd(`BRF_OFF_ACCESS, {31'h0, (s == 1 && a[0]) || (s == 2 && a != 0)}, "align", 32'h1);
      end
    end
    wr(`BRF_OFF_STATUS, 32'h0000_0033);
    chk({31'h0, compact_state}, 32'h1, "t");
    wr(`BRF_OFF_COND, 32'hF000_0000);
    rd(`BRF_OFF_COND, 32'h1, "t cond", 32'h1);
    wr(g(15), 32'h0000_0201);
    wr(`BRF_OFF_CALL, 32'h0000_0301);
    rd(g(14), 32'h0000_0202, "link");
    wr(`BRF_OFF_STEP, 32'h0);
    rd(g(15), 32'h0000_0306, "step");
    $display("test cond done");
  endtask : t_cond

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // reset three cycles, then the scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    last_mode = `BRF_MODE_SVC;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bank();
    t_fiq();
    t_prio();
    t_cond();
    give_verdict();
  end
endmodule : brf_core_state_tb

bind brf_core_state brf_core_state_chk CHK (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rresp, .rdata,
  .cur_mode, .compact_state, .privileged, .exc_taken);
